// >>> design/multifunction_pin_routing.sv
// module: routing of the seven shared terminals and misc outputs
// Contract
// - pin 0: host int, gpio 0, event, led, video, audio, or irq
// - pin 1: gpio 1, event, led, video, audio, or irq
// - serial mode when both serial pins are pulled up by the board
// - serial mode: pin 1 carries two-wire data
// - serial mode: pin 4 drives two-wire clock
// - serial mode: after each bus reset, read defaults from eeprom over two wires
// - pin 2: dma request, gpio 2, led, video, audio, event, ring, irq
// - pin 3: legacy irq or serialized interrupt
// - pin 4: lock, gpio 3, led, ring, video, audio, event, or irq
// - pin 5: dma grant, gpio 4, led, video, audio, event, or irq
// - pin 6: clock-run control or legacy irq
// - ring/power output carries ring indicate or power event
// - suspend input keeps the pin select through bus reset
// - speaker to host is card speaker xor card audio
module multifunction_pin_routing
   import pin_routing_pkg::*;
#(
   parameter int HALF_CYC = SER_HALF_CYC,
   parameter int NBITS = SER_BITS
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic suspend_n_in,
   input wire logic sel_wr_in,
   input wire logic [NUM_PINS*SEL_W-1:0] sel_data_in,
   input wire logic [GPIO_W-1:0] general_output_in,
   input wire logic ring_not_power_in,
   input wire sources_t src_in,
   input wire logic [NUM_PINS-1:0] shared_pin_in,
   input wire logic card_speaker_in,
   input wire logic card_audio_in,
   output pin_drive_t shared_pin_out,
   output logic [GPIO_W-1:0] general_input_out,
   output logic dma_gnt_out,
   output logic lock_out,
   output logic clkrun_out,
   output logic ring_power_n_out,
   output logic speaker_to_host_out,
   output logic serial_mode_out,
   output logic [NBITS-1:0] boot_data_out,
   output logic boot_busy_out
);
   if (HALF_CYC < 1 || NBITS < 2) begin
      $error("multifunction_pin_routing: bad parameter");
   end

   // ************************************************
   // state
   // ************************************************
   // kept apart: no async clear, so the select survives a suspended reset
   typedef struct packed {
      logic [NUM_PINS*SEL_W-1:0] sel;
      logic [NUM_PINS-1:0] sync1;
      logic [NUM_PINS-1:0] sync2;
      logic susp_n1;
      logic susp_n2;
      logic rst_sync1;
      logic rst_sync2;
      logic [1:0] aud_sync1;
      logic [1:0] aud_sync2;
   } keep_state_t;

   typedef struct packed {
      logic rst_seen;
      logic boot_go;
      logic serial_mode;
      pin_drive_t drive;
      logic [GPIO_W-1:0] gpi;
      logic dma_gnt;
      logic lock;
      logic clkrun;
      logic ring_power_n;
      logic speaker;
   } route_state_t;

   route_state_t state_ff;
   route_state_t nxt_state;
   keep_state_t keep_ff;
   keep_state_t nxt_keep;
   logic ser_scl;
   logic ser_sda_oe_n;
   logic ser_busy;

   serial_boot_loader #(
      .HALF_CYC(HALF_CYC),
      .NBITS(NBITS)
   ) u_loader (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .start_in(state_ff.boot_go),
      .sda_in(keep_ff.sync2[1]),
      .scl_out(ser_scl),
      .sda_oe_n_out(ser_sda_oe_n),
      .busy_out(ser_busy),
      .data_out(boot_data_out)
   );

   function automatic logic [1:0] route(input pin_fn_t fn, input int p,
                                        input logic gpo_bit);
      logic [1:0] r;
      r = 2'b00;
      unique case (fn)
         FN_GPO: r = {1'b1, gpo_bit};
         FN_GPE: r = {1'b1, src_in.general_purpose_event};
         FN_LED: r = {1'b1, src_in.led};
         FN_VIDEO: r = {1'b1, src_in.video};
         FN_AUDIO: r = {1'b1, src_in.audio_pwm};
         FN_IRQ: r = {1'b1, src_in.irq[p % IRQ_W]};
         FN_HOSTINT: r = {1'b1, src_in.host_int};
         // grant comes from the chipset, so pin 5 only listens
         FN_DMA: r = (p == 5) ? 2'b00 : {1'b1, src_in.dma_req};
         FN_RING: r = {1'b1, src_in.ring};
         FN_LOCK: r = {1'b1, src_in.lock};
         FN_SERIRQ: r = {1'b1, src_in.ser_irq};
         FN_CLKRUN: r = {1'b1, src_in.clkrun};
         default: r = 2'b00;
      endcase
      return r;
   endfunction : route

   // legal function per pin; anything else falls back to input
   function automatic logic allowed(input int p, input pin_fn_t fn);
      logic ok;
      ok = (fn == FN_INPUT) || (fn == FN_IRQ);
      unique case (p)
         0: ok = ok || fn inside {FN_HOSTINT, FN_GPO, FN_GPE, FN_LED,
                  FN_VIDEO, FN_AUDIO};
         1: ok = ok || fn inside {FN_GPO, FN_GPE, FN_LED, FN_VIDEO,
                  FN_AUDIO};
         2: ok = ok || fn inside {FN_DMA, FN_GPO, FN_LED, FN_VIDEO,
                  FN_AUDIO, FN_GPE, FN_RING};
         3: ok = ok || (fn == FN_SERIRQ);
         4: ok = ok || fn inside {FN_LOCK, FN_GPO, FN_LED, FN_RING,
                  FN_VIDEO, FN_AUDIO, FN_GPE};
         5: ok = ok || fn inside {FN_DMA, FN_GPO, FN_LED, FN_VIDEO,
                  FN_AUDIO, FN_GPE};
         6: ok = ok || (fn == FN_CLKRUN);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : allowed

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      logic [1:0] r;
      pin_fn_t fn;
      int gp;
      r = 2'b00;
      fn = FN_INPUT;
      gp = 0;
      nxt_keep = keep_ff;
      nxt_keep.sync1 = shared_pin_in;
      nxt_keep.sync2 = keep_ff.sync1;
      nxt_keep.susp_n1 = suspend_n_in;
      nxt_keep.susp_n2 = keep_ff.susp_n1;
      nxt_keep.rst_sync1 = rst_in;
      nxt_keep.rst_sync2 = keep_ff.rst_sync1;
      nxt_keep.aud_sync1 = {card_speaker_in, card_audio_in};
      nxt_keep.aud_sync2 = keep_ff.aud_sync1;
      // cleared by the synchronised reset unless suspend shields it
      if (keep_ff.rst_sync2 && keep_ff.susp_n2) begin
         nxt_keep.sel = {NUM_PINS{SEL_RESET}};
      end else if (sel_wr_in) begin
         nxt_keep.sel = sel_data_in;
      end
      nxt_state = state_ff;
      nxt_state.rst_seen = 1'b0;
      // only a board with both pull-ups gets a boot read
      nxt_state.boot_go = state_ff.rst_seen & keep_ff.sync2[1]
                          & keep_ff.sync2[4];
      // pins 1 and 4 pulled high by the board at reset select serial mode
      if (state_ff.rst_seen) begin
         nxt_state.serial_mode = keep_ff.sync2[1]
                                 & keep_ff.sync2[4];
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         fn = pin_fn_t'(keep_ff.sel[p*SEL_W +: SEL_W]);
         gp = (p == 0) ? 0 : (p == 1) ? 1 : (p == 2) ? 2 : (p == 4) ? 3 : 4;
         if (!allowed(p, fn)) begin
            fn = FN_INPUT;
         end
         r = route(fn, p, general_output_in[gp]);
         nxt_state.drive.out[p] = r[0];
         nxt_state.drive.oe_n[p] = ~r[1];
      end
      for (int g = 0; g < GPIO_W; g++) begin
         gp = (g < 3) ? g : (g == 3) ? 4 : 5;
         nxt_state.gpi[g] = keep_ff.sync2[gp];
      end
      if (state_ff.serial_mode) begin
         nxt_state.drive.out[1] = 1'b0;
         nxt_state.drive.oe_n[1] = ser_sda_oe_n;
         nxt_state.drive.out[4] = ser_scl;
         nxt_state.drive.oe_n[4] = 1'b0;
      end
      nxt_state.dma_gnt = keep_ff.sync2[5];
      nxt_state.lock = keep_ff.sync2[4];
      nxt_state.clkrun = keep_ff.sync2[6];
      nxt_state.ring_power_n = ring_not_power_in ? ~src_in.ring
                                                 : ~src_in.power_event;
      // card pins are asynchronous: xor only after the synchroniser
      nxt_state.speaker = keep_ff.aud_sync2[1]
                          ^ keep_ff.aud_sync2[0];
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff.rst_seen <= 1'b1;
         state_ff.boot_go <= 1'b0;
         state_ff.serial_mode <= 1'b0;
         state_ff.drive <= '{out: '0, oe_n: '1};
         state_ff.gpi <= '0;
         state_ff.dma_gnt <= 1'b0;
         state_ff.lock <= 1'b0;
         state_ff.clkrun <= 1'b0;
         state_ff.ring_power_n <= 1'b1;
         state_ff.speaker <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // no reset: synchronisers keep sampling, select obeys suspend
   always_ff @(posedge sys_clk_in) begin
      keep_ff <= nxt_keep;
   end

   assign shared_pin_out = state_ff.drive;
   assign general_input_out = state_ff.gpi;
   assign dma_gnt_out = state_ff.dma_gnt;
   assign lock_out = state_ff.lock;
   assign clkrun_out = state_ff.clkrun;
   assign ring_power_n_out = state_ff.ring_power_n;
   assign speaker_to_host_out = state_ff.speaker;
   assign serial_mode_out = state_ff.serial_mode;
   assign boot_busy_out = ser_busy;
endmodule : multifunction_pin_routing

// >>> design/serial_boot_loader.sv
// module: two-wire read of configuration defaults after bus reset
module serial_boot_loader
   import pin_routing_pkg::*;
#(
   parameter int HALF_CYC = SER_HALF_CYC,
   parameter int NBITS = SER_BITS
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_n_out,
   output logic busy_out,
   output logic [NBITS-1:0] data_out
);
   // tick is 16 bits wide and the shift needs at least two bits
   if (HALF_CYC < 1 || HALF_CYC > 65536 || NBITS < 2 || NBITS > 255) begin
      $error("serial_boot_loader: bad parameter");
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOW = 2'b01,
      ST_HIGH = 2'b10
   } ser_st_t;

   typedef struct packed {
      ser_st_t st;
      logic [15:0] tick;
      logic [SER_CNT_W-1:0] bit_cnt;
      logic scl;
      logic busy;
      logic [NBITS-1:0] data;
   } ser_state_t;

   ser_state_t state_ff;
   ser_state_t nxt_state;

   // simple read: clock out bits, sample data on rising clock edge
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff.st)
         ST_IDLE: begin
            nxt_state.scl = 1'b1;
            if (start_in) begin
               nxt_state.st = ST_LOW;
               nxt_state.tick = 16'h0000;
               nxt_state.bit_cnt = '0;
               nxt_state.scl = 1'b0;
            end
         end
         ST_LOW: begin
            nxt_state.tick = state_ff.tick + 16'h0001;
            if (state_ff.tick == 16'(HALF_CYC - 1)) begin
               nxt_state.tick = 16'h0000;
               nxt_state.scl = 1'b1;
               nxt_state.st = ST_HIGH;
               nxt_state.data = {state_ff.data[NBITS-2:0], sda_in};
            end
         end
         ST_HIGH: begin
            nxt_state.tick = state_ff.tick + 16'h0001;
            if (state_ff.tick == 16'(HALF_CYC - 1)) begin
               nxt_state.tick = 16'h0000;
               nxt_state.bit_cnt = state_ff.bit_cnt + 1'b1;
               if (state_ff.bit_cnt == SER_CNT_W'(NBITS - 1)) begin
                  nxt_state.st = ST_IDLE;
               end else begin
                  nxt_state.scl = 1'b0;
                  nxt_state.st = ST_LOW;
               end
            end
         end
         default: nxt_state.st = ST_IDLE;
      endcase
      nxt_state.busy = (nxt_state.st != ST_IDLE);
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= '{st: ST_IDLE, scl: 1'b1, default: '0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign scl_out = state_ff.scl;
   assign sda_oe_n_out = 1'b1;
   assign busy_out = state_ff.busy;
   assign data_out = state_ff.data;
endmodule : serial_boot_loader

// >>> shared/pin_routing_pkg.sv
// package: constants and carriers for the shared pin routing block
package pin_routing_pkg;
   localparam int NUM_PINS = 7;
   localparam int SEL_W = 4;
   localparam int GPIO_W = 5;
   localparam int IRQ_W = 4;
   localparam int SER_BIT_W = 9;
   localparam int SER_CNT_W = 8;
   localparam int SER_HALF_NS = 5000;
   localparam int CLK_NS = 5;
   localparam int SER_HALF_CYC = SER_HALF_NS / CLK_NS;
   localparam int SER_BITS = 48;

   // per-pin function codes; zero is always the harmless input state
   typedef enum logic [3:0] {
      FN_INPUT = 4'h0,
      FN_GPO = 4'h1,
      FN_GPE = 4'h2,
      FN_LED = 4'h3,
      FN_VIDEO = 4'h4,
      FN_AUDIO = 4'h5,
      FN_IRQ = 4'h6,
      FN_HOSTINT = 4'h7,
      FN_DMA = 4'h8,
      FN_RING = 4'h9,
      FN_LOCK = 4'hA,
      FN_SERIRQ = 4'hB,
      FN_CLKRUN = 4'hC
   } pin_fn_t;

   typedef struct packed {
      logic host_int;
      logic general_purpose_event;
      logic led;
      logic video;
      logic audio_pwm;
      logic [IRQ_W-1:0] irq;
      logic dma_req;
      logic dma_gnt;
      logic ring;
      logic power_event;
      logic lock;
      logic ser_irq;
      logic clkrun;
   } sources_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe_n;
   } pin_drive_t;

   localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
endpackage : pin_routing_pkg

// >>> tb/board_eeprom.sv
// partner: board pull-ups, pad levels and a serial eeprom
module board_eeprom
   import pin_routing_pkg::*;
#(
   parameter logic [7:0] PATTERN = 8'h81
) (
   input wire logic rst_in,
   input wire logic pull_up_in,
   input wire logic [NUM_PINS-1:0] ext_in,
   input wire pin_drive_t pin_out_in,
   output logic [NUM_PINS-1:0] pin_level_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NUM_PINS-1:0] far;
   int idx;
   // next bit on each falling serial clock
   always @(negedge pin_level_out[4] or posedge rst_in) begin
      idx <= rst_in ? 0 : idx + 1;
   end
   always_comb begin
      far = ext_in;
      if (pull_up_in) begin
         far[4] = 1'b1;
         far[1] = PATTERN[idx[2:0]];
      end
      for (int p = 0; p < NUM_PINS; p++) begin
         pin_level_out[p] = pin_out_in.oe_n[p] ? far[p] : pin_out_in.out[p];
      end
      // open drain data: a low from the eeprom wins
      pin_level_out[1] &= far[1] | !pull_up_in;
   end
endmodule : board_eeprom

// >>> tb/pin_routing_monitor.sv
// checker: port properties of the shared pin routing
module pin_routing_monitor
   import pin_routing_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic sel_wr_in,
   input wire logic [NUM_PINS*SEL_W-1:0] sel_data_in,
   input wire logic [GPIO_W-1:0] general_output_in,
   input wire logic ring_not_power_in,
   input wire sources_t src_in,
   input wire logic card_speaker_in,
   input wire logic card_audio_in,
   input wire pin_drive_t shared_pin_out,
   input wire logic ring_power_n_out,
   input wire logic speaker_to_host_out,
   input wire logic serial_mode_out,
   input wire logic boot_busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // properties
   // ****
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // a lone write, then the drive shows one edge later
   sequence s_wr(p, c);
      sel_wr_in && sel_data_in[4*p+:4] == c ##1 !sel_wr_in;
   endsequence
   a_reset_idle: assert property (disable iff (1'b0) rst_in |->
      &shared_pin_out.oe_n && shared_pin_out.out == '0 && ring_power_n_out)
      else $error("pins not idle in reset");
   a_input_write: assert property (s_wr(0, 4'h0) |-> ##1
      shared_pin_out.oe_n[0]) else $error("pin 0 driven");
   a_gpo_drive: assert property (s_wr(0, 4'h1) |-> ##1
      !shared_pin_out.oe_n[0]
      && shared_pin_out.out[0] == $past(general_output_in[0]))
      else $error("pin 0 not output 0");
   a_pin3_refuse: assert property (s_wr(3, 4'h1) |-> ##1
      shared_pin_out.oe_n[3]) else $error("pin 3 took gpo");
   a_speaker_xor: assert property (!$past(rst_in) |->
      speaker_to_host_out == $past(card_speaker_in ^ card_audio_in, 3))
      else $error("speaker not xor");
   a_ring_power: assert property (!$past(rst_in) |->
      ring_power_n_out == !$past(ring_not_power_in ? src_in.ring
      : src_in.power_event)) else $error("ring output wrong");
   a_boot_start: assert property ($rose(serial_mode_out) |->
      ##[0:2] boot_busy_out) else $error("boot not started");
   a_no_boot: assert property (!serial_mode_out |->
      !boot_busy_out) else $error("boot without serial");
endmodule : pin_routing_monitor

bind multifunction_pin_routing pin_routing_monitor mon (.sys_clk_in,
   .rst_in, .sel_wr_in, .sel_data_in, .general_output_in,
   .ring_not_power_in, .src_in, .card_speaker_in, .card_audio_in,
   .shared_pin_out, .ring_power_n_out, .speaker_to_host_out,
   .serial_mode_out, .boot_busy_out);

// >>> tb/testbench.sv
// bench: shared pin routing against board and eeprom model
module testbench
   import pin_routing_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, sus_n, wr, rnp, spk, aud, pull, busy, smode, scl_seen;
   logic gnt, lck, crun, rpn, spo;
   logic [NUM_PINS*SEL_W-1:0] sel;
   logic [GPIO_W-1:0] gpo, gin;
   logic [NUM_PINS-1:0] pins, ext;
   logic [7:0] bdata;
   sources_t src;
   pin_drive_t po;
   int n_fail, cmp_count;
   // rows per pin: the function codes that drive it
   logic [15:0] drv[NUM_PINS] = '{16'h00FE, 16'h007E, 16'h037E, 16'h0840,
      16'h067E, 16'h007E, 16'h1040};

   multifunction_pin_routing #(.HALF_CYC(2), .NBITS(8)) dut (
      .sys_clk_in(clk), .rst_in(rst), .suspend_n_in(sus_n),
      .sel_wr_in(wr), .sel_data_in(sel), .general_output_in(gpo),
      .ring_not_power_in(rnp), .src_in(src), .shared_pin_in(pins),
      .card_speaker_in(spk), .card_audio_in(aud), .shared_pin_out(po),
      .general_input_out(gin), .dma_gnt_out(gnt), .lock_out(lck),
      .clkrun_out(crun), .ring_power_n_out(rpn),
      .speaker_to_host_out(spo), .serial_mode_out(smode),
      .boot_data_out(bdata), .boot_busy_out(busy));
   board_eeprom far_end (.rst_in(rst), .pull_up_in(pull), .ext_in(ext),
      .pin_out_in(po), .pin_level_out(pins));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****
   // tasks
   // ****
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %0h not %0h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   task automatic put_sel(input logic [NUM_PINS*SEL_W-1:0] v);
      @(negedge clk);
      sel = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      repeat (2) @(negedge clk);
   endtask : put_sel

   task automatic do_reset(input logic pu);
      @(negedge clk);
      pull = pu;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask : do_reset

   // ****
   // main sequence
   // ****
   initial begin
      {rst, sus_n, wr, rnp, spk, aud, pull} = 7'h60;
      sel = '0;
      gpo = '0;
      src = '0;
      ext = '0;
      do_reset(1'b0);
      check(po.oe_n, 7'h7F);
      for (int lv = 0; lv < 2; lv++) begin
         for (int c = 0; c < 16; c++) begin
            src = {$bits(sources_t){lv[0]}};
            gpo = {GPIO_W{lv[0]}};
            put_sel({NUM_PINS{c[3:0]}});
            for (int p = 0; p < NUM_PINS; p++) begin
               check(po.oe_n[p], !drv[p][c]);
               if (drv[p][c]) begin
                  check(po.out[p], lv[0]);
               end
            end
         end
      end
      $display("routing table done");
      for (int k = 0; k < 2; k++) begin
         ext = k[0] ? 7'h4A : 7'h35;
         repeat (4) @(negedge clk);
         check(gin, {ext[5], ext[4], ext[2:0]});
         check({gnt, lck, crun}, {ext[5], ext[4], ext[6]});
      end
      for (int i = 0; i < 8; i++) begin
         {spk, aud, rnp} = i[2:0];
         src.ring = i[1];
         src.power_event = i[2];
         // card pins pass a two-stage synchroniser first
         repeat (3) @(negedge clk);
         check(spo, i[2] ^ i[1]);
         check(rpn, !(i[0] ? i[1] : i[2]));
      end
      $display("inputs and misc outputs done");
      put_sel({NUM_PINS{4'h1}});
      sus_n = 1'b0;
      do_reset(1'b0);
      check(po.oe_n, 7'h48);
      sus_n = 1'b1;
      do_reset(1'b0);
      check(po.oe_n, 7'h7F);
      do_reset(1'b1);
      check({smode, busy}, 2'h3);
      scl_seen = 1'b0;
      for (int t = 0; busy !== 1'b0; t++) begin
         if (t == 500) begin
            n_fail++;
            break;
         end
         if (pins[4] === 1'b0) begin
            scl_seen = 1'b1;
         end
         @(negedge clk);
      end
      check(scl_seen, 1'b1);
      check(bdata, 8'h81);
      do_reset(1'b0);
      check(smode, 1'b0);
      $display("suspend and serial boot done");
      end_of_test();
   end
endmodule : testbench
